/* File: rtl/sel_consts.vh */
// constants for the source event logger: offsets, fields, codes, timing
`ifndef SEL_CONSTS_VH
`define SEL_CONSTS_VH

// register byte offsets
`define SEL_REG_ENABLE 12'h000
`define SEL_REG_WARN 12'h004
`define SEL_REG_IRQ_STATUS 12'h008
`define SEL_REG_IRQ_MASK 12'h00c
`define SEL_REG_LOG_FILL 12'h010
`define SEL_REG_LOG_INDEX 12'h014
`define SEL_REG_LOG_TIME 12'h018
`define SEL_REG_LOG_INFO 12'h01c
`define SEL_REG_UNBAL_LIMIT 12'h020
`define SEL_REG_GEN_WAIT 12'h024

// enable register fields
`define SEL_EN_UNBAL 0
`define SEL_EN_GEN_INVALID 1
`define SEL_EN_GEN_START 2
`define SEL_EN_NEUTRAL_SEQ 3
`define SEL_EN_NEUTRAL_LOSS 4
`define SEL_EN_OVER_VOLT 5
`define SEL_EN_FREQ 6
`define SEL_EN_WIDTH 7

// interrupt status fields
`define SEL_IRQ_LOGGED 0
`define SEL_IRQ_WARNING 1

// event indices and codes
`define SEL_EVENTS 22
`define SEL_WARNINGS 10
`define SEL_IDX_FIRST_EVENT 10
`define SEL_CODE_EVENT_BASE 8'd60
`define SEL_CODE_GEN_INVALID 8'd30
`define SEL_CODE_GEN_START 8'd31
`define SEL_CODE_TEST_ON 8'd40
`define SEL_CODE_TEST_OFF 8'd41
`define SEL_CODE_UNBAL 8'd50
`define SEL_CODE_NEUTRAL_SEQ 8'd52
`define SEL_CODE_NEUTRAL_LOSS 8'd54
`define SEL_CODE_UNDER_VOLT 8'd70
`define SEL_CODE_OVER_FREQ_HI 8'd79
`define SEL_CODE_NO_VOLT 8'd74
`define SEL_CODE_RECOVER 8'd80

// thresholds in percent
`define SEL_UNBAL_LIMIT_RESET 8'd5
`define SEL_NEUTRAL_LOSS_PCT 8'd20

// log sizes
`define SEL_LOG_DEPTH 99
`define SEL_DISP_DEPTH 20

// timing
`define SEL_CLOCK_MHZ 125
`define SEL_GEN_WAIT_US 1000
`define SEL_GEN_WAIT_CYCLES (`SEL_GEN_WAIT_US * `SEL_CLOCK_MHZ)
`define SEL_BLINK_MS 250
`define SEL_BLINK_CYCLES (`SEL_BLINK_MS * 1000 * `SEL_CLOCK_MHZ)

// source led states
`define SEL_LED_OFF 2'd0
`define SEL_LED_ON 2'd1
`define SEL_LED_BLINK 2'd2

`endif

/* File: rtl/sel_source_event_logger.v */
// source event logger: condition watch, warnings, event log, apb registers
`timescale 1ns/1ps
`include "sel_consts.vh"

module sel_source_event_logger #(
	parameter LOG_DEPTH = `SEL_LOG_DEPTH,
	parameter DISP_DEPTH = `SEL_DISP_DEPTH,
	parameter [31:0] GEN_WAIT_CYCLES = `SEL_GEN_WAIT_CYCLES,
	parameter [31:0] BLINK_CYCLES = `SEL_BLINK_CYCLES,
	parameter NEUTRAL_SEQ_EN_RESET = 1
) (
	input wire clock,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output reg pslverr,
	output wire irq,
	input wire [1:0] srcConnected,
	input wire [7:0] unbalanceFirst,
	input wire [7:0] unbalanceSecond,
	input wire alternatePresent,
	input wire generatorStart,
	input wire generatorReady,
	input wire [1:0] testFailed,
	input wire [1:0] neutralSeqWrong,
	input wire [1:0] underVoltage,
	input wire [1:0] overVoltage,
	input wire [1:0] noVoltage,
	input wire [1:0] underFrequency,
	input wire [1:0] overFrequency,
	input wire [1:0] inRange,
	input wire [31:0] timestamp,
	input wire [3:0] transferMode,
	output reg [1:0] sourceLed,
	output reg [7:0] bottomBarCode,
	output reg [`SEL_WARNINGS-1:0] warnPending,
	input wire [4:0] dispIndex,
	output reg dispValid,
	output reg [31:0] dispTime,
	output reg [7:0] dispStatus,
	output reg [7:0] dispCode,
	output reg [3:0] dispMode
);

	localparam ENTRY_W = 52;
	localparam [6:0] DEPTH7 = LOG_DEPTH;
	localparam [6:0] DISP7 = DISP_DEPTH;

	// event code for an event index
	function [7:0] evCode;
		input [4:0] idx;
		begin
			case (idx)
				5'd0: evCode = `SEL_CODE_GEN_INVALID;
				5'd1: evCode = `SEL_CODE_GEN_START;
				5'd2: evCode = `SEL_CODE_TEST_ON;
				5'd3: evCode = `SEL_CODE_TEST_OFF;
				5'd4: evCode = `SEL_CODE_UNBAL;
				5'd5: evCode = `SEL_CODE_UNBAL + 8'd1;
				5'd6: evCode = `SEL_CODE_NEUTRAL_SEQ;
				5'd7: evCode = `SEL_CODE_NEUTRAL_SEQ + 8'd1;
				5'd8: evCode = `SEL_CODE_NEUTRAL_LOSS;
				5'd9: evCode = `SEL_CODE_NEUTRAL_LOSS + 8'd1;
				default: evCode = `SEL_CODE_EVENT_BASE + {3'h0, idx};
			endcase
		end
	endfunction

	// ring slot of the entry that lies back entries behind the newest
	function [6:0] ringPos;
		input [6:0] wp;
		input [6:0] back;
		reg [7:0] sum;
		begin
			sum = {1'b0, wp} + {1'b0, DEPTH7} - 8'h01 - {1'b0, back};
			// wrap in full width so the top bit is never lost
			if (sum >= {1'b0, DEPTH7})
				sum = sum - {1'b0, DEPTH7};
			ringPos = sum[6:0];
		end
	endfunction

	reg [`SEL_EN_WIDTH-1:0] enable;
	reg [1:0] irqStatus;
	reg [1:0] irqMask;
	reg [6:0] logIndex;
	reg [7:0] unbalLimit;
	reg [31:0] genWait;
	reg [31:0] genTimer;
	reg genTimerRun;
	reg genExpired;
	reg [`SEL_EVENTS-1:0] condPrev;
	reg [`SEL_EVENTS-1:0] pending;
	reg [ENTRY_W-1:0] logMem [0:LOG_DEPTH-1];
	reg [6:0] writePtr;
	reg [6:0] fillCount;
	reg [1:0] ledState0;
	reg [1:0] ledState1;
	reg [31:0] blinkCount;
	reg blinkPhase;
	reg [`SEL_EVENTS-1:0] cond;
	reg [`SEL_EVENTS-1:0] evEnable;
	reg [4:0] grantIdx;
	reg grantValid;
	reg [7:0] grantCode;
	reg [31:0] next_prdata;
	reg next_pslverr;
	integer i;

	wire setupPhase = psel & ~penable;
	wire accessPhase = psel & penable;
	wire busWrite = accessPhase & pwrite;
	wire busRead = accessPhase & ~pwrite;
	wire [`SEL_EVENTS-1:0] rise = cond & ~condPrev & evEnable;
	wire [`SEL_EVENTS-1:0] grantMask = grantValid ? ({{(`SEL_EVENTS-1){1'b0}}, 1'b1} << grantIdx) : {`SEL_EVENTS{1'b0}};
	wire [7:0] srcStatus = {2'b00, srcConnected, inRange, noVoltage};
	wire [ENTRY_W-1:0] busEntry = logMem[ringPos(writePtr, logIndex)];
	wire newWarning = |rise[`SEL_WARNINGS-1:0];

	assign pready = 1'b1;
	assign irq = |(irqStatus & irqMask);

	// raw conditions per event index
	always @*
	begin
		cond = {`SEL_EVENTS{1'b0}};
		cond[0] = ~alternatePresent;
		cond[1] = genExpired;
		cond[3:2] = testFailed;
		cond[4] = srcConnected[0] & (unbalanceFirst > unbalLimit);
		cond[5] = srcConnected[1] & (unbalanceSecond > unbalLimit);
		cond[7:6] = neutralSeqWrong;
		cond[8] = srcConnected[0] & (unbalanceFirst > `SEL_NEUTRAL_LOSS_PCT);
		cond[9] = srcConnected[1] & (unbalanceSecond > `SEL_NEUTRAL_LOSS_PCT);
		cond[11:10] = underVoltage;
		cond[13:12] = overVoltage;
		cond[15:14] = noVoltage;
		cond[17:16] = underFrequency;
		cond[19:18] = overFrequency;
		cond[21:20] = inRange;
	end

	// per-event enables, fixed ones always on
	always @*
	begin
		evEnable = {`SEL_EVENTS{1'b1}};
		evEnable[0] = enable[`SEL_EN_GEN_INVALID];
		evEnable[1] = enable[`SEL_EN_GEN_START];
		evEnable[5:4] = {2{enable[`SEL_EN_UNBAL]}};
		evEnable[7:6] = {2{enable[`SEL_EN_NEUTRAL_SEQ]}};
		evEnable[9:8] = {2{enable[`SEL_EN_NEUTRAL_LOSS]}};
		evEnable[13:12] = {2{enable[`SEL_EN_OVER_VOLT]}};
		evEnable[19:16] = {4{enable[`SEL_EN_FREQ]}};
	end

	// pick the lowest pending event to log this cycle
	always @*
	begin
		grantIdx = 5'd0;
		grantValid = 1'b0;
		for (i = `SEL_EVENTS - 1; i >= 0; i = i - 1)
		begin
			if (pending[i])
			begin
				grantIdx = i[4:0];
				grantValid = 1'b1;
			end
		end
		grantCode = evCode(grantIdx);
	end

	// edge memory and queue of events awaiting a log slot
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			condPrev <= {`SEL_EVENTS{1'b0}};
			pending <= {`SEL_EVENTS{1'b0}};
		end
		else
		begin
			condPrev <= cond;
			pending <= (pending & ~grantMask) | rise;
		end
	end

	// generator ready wait timer
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			genTimer <= 32'h0000_0000;
			genTimerRun <= 1'b0;
			genExpired <= 1'b0;
		end
		else if (!generatorStart || generatorReady)
		begin
			genTimer <= 32'h0000_0000;
			genTimerRun <= generatorStart & ~generatorReady;
			genExpired <= 1'b0;
		end
		else if (!genTimerRun)
		begin
			genTimer <= 32'h0000_0000;
			genTimerRun <= 1'b1;
		end
		else if (genTimer + 32'h0000_0001 >= genWait)
			genExpired <= 1'b1;
		else
			genTimer <= genTimer + 32'h0000_0001;
	end

	// pending warnings: set on event, cleared by ack, set wins
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			warnPending <= {`SEL_WARNINGS{1'b0}};
		else
		begin
			warnPending <= (warnPending & ~((busWrite && paddr == `SEL_REG_WARN) ? pwdata[`SEL_WARNINGS-1:0]
				: {`SEL_WARNINGS{1'b0}})) | rise[`SEL_WARNINGS-1:0];
			if (|inRange && !rise[1])
				warnPending[1] <= 1'b0;
		end
	end

	// circular log: write pointer and fill count, no clear path
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			writePtr <= 7'd0;
			fillCount <= 7'd0;
		end
		else if (grantValid)
		begin
			writePtr <= (writePtr == DEPTH7 - 7'd1) ? 7'd0 : writePtr + 7'd1;
			if (fillCount != DEPTH7)
				fillCount <= fillCount + 7'd1;
		end
	end

	// entry store, oldest slot reused once full
	always @(posedge clock)
	begin
		if (grantValid)
			logMem[writePtr] <= {timestamp, srcStatus, grantCode, transferMode};
	end

	// source led state and bottom bar from the logged code
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ledState0 <= `SEL_LED_OFF;
			ledState1 <= `SEL_LED_OFF;
			bottomBarCode <= 8'h00;
		end
		else if (grantValid)
		begin
			if (grantCode < `SEL_CODE_NEUTRAL_LOSS)
				bottomBarCode <= grantCode;
			else if (grantCode == `SEL_CODE_NO_VOLT || grantCode == `SEL_CODE_NO_VOLT + 8'd1)
			begin
				if (grantCode[0])
					ledState1 <= `SEL_LED_OFF;
				else
					ledState0 <= `SEL_LED_OFF;
			end
			else if (grantCode >= `SEL_CODE_RECOVER)
			begin
				if (grantCode[0])
					ledState1 <= `SEL_LED_ON;
				else
					ledState0 <= `SEL_LED_ON;
			end
			else if (grantCode[0])
				ledState1 <= `SEL_LED_BLINK;
			else
				ledState0 <= `SEL_LED_BLINK;
		end
	end

	// blink timebase and led drive
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			blinkCount <= 32'h0000_0000;
			blinkPhase <= 1'b0;
			sourceLed <= 2'b00;
		end
		else
		begin
			if (blinkCount + 32'h0000_0001 >= BLINK_CYCLES)
			begin
				blinkCount <= 32'h0000_0000;
				blinkPhase <= ~blinkPhase;
			end
			else
				blinkCount <= blinkCount + 32'h0000_0001;
			sourceLed[0] <= (ledState0 == `SEL_LED_ON) | ((ledState0 == `SEL_LED_BLINK) & blinkPhase);
			sourceLed[1] <= (ledState1 == `SEL_LED_ON) | ((ledState1 == `SEL_LED_BLINK) & blinkPhase);
		end
	end

	// display port: newest entries only
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dispValid <= 1'b0;
			{dispTime, dispStatus, dispCode, dispMode} <= {ENTRY_W{1'b0}};
		end
		else
		begin
			dispValid <= ({2'b00, dispIndex} < DISP7) && ({2'b00, dispIndex} < fillCount);
			{dispTime, dispStatus, dispCode, dispMode} <= logMem[ringPos(writePtr, {2'b00, dispIndex})];
		end
	end

	// register writes and interrupt status
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			enable <= {`SEL_EN_WIDTH{1'b0}};
			enable[`SEL_EN_NEUTRAL_SEQ] <= (NEUTRAL_SEQ_EN_RESET != 0);
			irqMask <= 2'b00;
			irqStatus <= 2'b00;
			logIndex <= 7'd0;
			unbalLimit <= `SEL_UNBAL_LIMIT_RESET;
			genWait <= GEN_WAIT_CYCLES;
		end
		else
		begin
			if (busWrite)
			begin
				case (paddr)
					`SEL_REG_ENABLE: enable <= pwdata[`SEL_EN_WIDTH-1:0];
					`SEL_REG_IRQ_MASK: irqMask <= pwdata[1:0];
					`SEL_REG_LOG_INDEX: logIndex <= pwdata[6:0];
					`SEL_REG_UNBAL_LIMIT: unbalLimit <= pwdata[7:0];
					`SEL_REG_GEN_WAIT: genWait <= pwdata;
					default: ;
				endcase
			end
			// read clears, a new event in the same cycle wins
			irqStatus <= ((busRead && paddr == `SEL_REG_IRQ_STATUS) ? 2'b00 : irqStatus)
				| {newWarning, grantValid};
		end
	end

	// read data prepared in the setup phase
	always @*
	begin
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		case (paddr)
			`SEL_REG_ENABLE: next_prdata[`SEL_EN_WIDTH-1:0] = enable;
			`SEL_REG_WARN: next_prdata[`SEL_WARNINGS-1:0] = warnPending;
			`SEL_REG_IRQ_STATUS: next_prdata[1:0] = irqStatus;
			`SEL_REG_IRQ_MASK: next_prdata[1:0] = irqMask;
			`SEL_REG_LOG_FILL: next_prdata[14:0] = {writePtr, 1'b0, fillCount};
			`SEL_REG_LOG_INDEX: next_prdata[6:0] = logIndex;
			`SEL_REG_LOG_TIME: next_prdata = (logIndex < fillCount) ? busEntry[51:20] : 32'h0000_0000;
			`SEL_REG_LOG_INFO: next_prdata[19:0] = (logIndex < fillCount) ? busEntry[19:0] : 20'h00000;
			`SEL_REG_UNBAL_LIMIT: next_prdata[7:0] = unbalLimit;
			`SEL_REG_GEN_WAIT: next_prdata = genWait;
			default: next_pslverr = 1'b1;
		endcase
	end

	// apb answer registers
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (setupPhase)
		begin
			prdata <= pwrite ? 32'h0000_0000 : next_prdata;
			pslverr <= next_pslverr;
		end
	end

endmodule

/* File: tb/sel_display_panel.sv */
// operator display panel: selects an entry and reads the registered view
`timescale 1ns/1ps
module sel_display_panel (
	input wire logic clock,
	input wire logic dispValid,
	input wire logic [7:0] dispCode,
	output logic [4:0] dispIndex
);
	initial dispIndex = 5'h00;
	// entry view follows the index one cycle later
	task automatic look(input logic [4:0] idx, output logic v, output logic [7:0] c);
		dispIndex <= idx;
		repeat (2) @(posedge clock);
		v = dispValid;
		c = dispCode;
	endtask
endmodule

/* File: tb/sel_logger_checker.sv */
// port-level assertions for the source event logger
`timescale 1ns/1ps
`include "sel_consts.vh"
module sel_logger_checker (
	input wire clock,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	input wire [1:0] testFailed,
	input wire [1:0] noVoltage,
	input wire [1:0] inRange,
	input wire [1:0] sourceLed,
	input wire [`SEL_WARNINGS-1:0] warnPending,
	input wire [4:0] dispIndex,
	input wire dispValid
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// acknowledge step and led windows
	sequence ackTestOn;
		psel && penable && pwrite && paddr == `SEL_REG_WARN && pwdata[2];
	endsequence
	sequence ledDark;
		(!sourceLed[0])[*5];
	endsequence
	sequence ledLit;
		sourceLed[0][*5];
	endsequence
	a_ready_high: assert property (psel && penable |-> pready) else $error("access without ready");
	a_bad_addr: assert property (psel && !penable && paddr > `SEL_REG_GEN_WAIT |=> pslverr)
		else $error("unmapped access without error");
	a_test_on: assert property ($rose(testFailed[0]) |=> warnPending[2]) else $error("on-load fail lost");
	a_test_off: assert property ($rose(testFailed[1]) |=> warnPending[3]) else $error("off-load fail lost");
	a_gen_clear: assert property (warnPending[1] && (|inRange) |=> !warnPending[1])
		else $error("start failure not cleared");
	a_warn_hold: assert property (warnPending[2] && !(psel && penable && pwrite) |=> warnPending[2])
		else $error("warning dropped without ack");
	a_ack_clear: assert property (ackTestOn ##0 !$rose(testFailed[0]) |=> !warnPending[2])
		else $error("ack did not clear");
	a_disp_limit: assert property (dispIndex > 5'h13 |=> !dispValid) else $error("display past limit");
	a_led_off: assert property ($rose(noVoltage[0]) |-> ##6 ledDark) else $error("led not off");
	a_led_on: assert property ($rose(inRange[0]) |-> ##6 ledLit) else $error("led not on");
endmodule
bind sel_source_event_logger sel_logger_checker sel_logger_checker_i (.clock(clock), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.testFailed(testFailed), .noVoltage(noVoltage), .inRange(inRange), .sourceLed(sourceLed),
	.warnPending(warnPending), .dispIndex(dispIndex), .dispValid(dispValid));

/* File: tb/testbench.sv */
// self-checking bench for the source event logger
`timescale 1ns/1ps
`include "sel_consts.vh"
`define CHK(nm, exp, got) begin checksDone++; if ((got) !== (exp)) begin nFail++; \
	$display("[ERR] %s exp %h got %h", nm, exp, got); end end
module testbench;
	typedef struct {logic [6:0] en; logic [31:0] stim; logic [7:0] code;} sel_row_t;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] stim = 32'h0;
	logic [31:0] timestamp = 32'h0;
	logic [31:0] prdata, rd, dispTime;
	logic pready, pslverr, irq, lastErr, dispValid, v;
	logic altPresent = 1'b1;
	logic genStart = 1'b0;
	logic [3:0] mode = 4'h0;
	logic [1:0] sourceLed;
	logic [7:0] bottomBarCode, dispStatus, dispCode, c;
	logic [9:0] warnPending;
	logic [4:0] dispIndex;
	logic [3:0] dispMode;
	int nFail = 0;
	int checksDone = 0;
	int fill = 0;
	int total = 0;
	// enable, stimulus {unbal2, unbal1, test, neutral, uv, ov, nv, uf, of, inrange}, code (0: none)
	sel_row_t rows[22] = '{'{7'h00, 32'h4000, 8'h28}, '{7'h00, 32'h8000, 8'h29}, '{7'h08, 32'h1000, 8'h34},
		'{7'h08, 32'h2000, 8'h35}, '{7'h00, 32'h0400, 8'h46}, '{7'h00, 32'h0800, 8'h47}, '{7'h20, 32'h0100, 8'h48},
		'{7'h20, 32'h0200, 8'h49}, '{7'h00, 32'h0040, 8'h4a}, '{7'h00, 32'h0080, 8'h4b}, '{7'h40, 32'h0010, 8'h4c},
		'{7'h40, 32'h0020, 8'h4d}, '{7'h40, 32'h0004, 8'h4e}, '{7'h40, 32'h0008, 8'h4f}, '{7'h00, 32'h0001, 8'h50},
		'{7'h00, 32'h0002, 8'h51}, '{7'h01, 32'h00060000, 8'h32}, '{7'h01, 32'h06000000, 8'h33},
		'{7'h10, 32'h00150000, 8'h36}, '{7'h10, 32'h15000000, 8'h37}, '{7'h01, 32'h00050000, 8'h00},
		'{7'h00, 32'h0100, 8'h00}};
	// clock and entry time base
	always #4 clock = ~clock;
	always @(posedge clock) timestamp <= timestamp + 32'h1;
	sel_source_event_logger #(.GEN_WAIT_CYCLES(32'd20), .BLINK_CYCLES(32'd4)) sel_source_event_logger_i (
		.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq), .srcConnected(2'b11),
		.unbalanceFirst(stim[23:16]), .unbalanceSecond(stim[31:24]), .alternatePresent(altPresent),
		.generatorStart(genStart), .generatorReady(1'b0), .testFailed(stim[15:14]), .neutralSeqWrong(stim[13:12]),
		.underVoltage(stim[11:10]), .overVoltage(stim[9:8]), .noVoltage(stim[7:6]), .underFrequency(stim[5:4]),
		.overFrequency(stim[3:2]), .inRange(stim[1:0]), .timestamp(timestamp), .transferMode(mode),
		.sourceLed(sourceLed), .bottomBarCode(bottomBarCode), .warnPending(warnPending), .dispIndex(dispIndex),
		.dispValid(dispValid), .dispTime(dispTime), .dispStatus(dispStatus), .dispCode(dispCode), .dispMode(dispMode));
	sel_display_panel sel_display_panel_i (.clock(clock), .dispValid(dispValid), .dispCode(dispCode),
		.dispIndex(dispIndex));
	// one apb transfer, setup then access until ready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// raise a condition, then drop it
	task automatic pulse(input logic [31:0] s);
		stim <= s;
		repeat (4) @(posedge clock);
		stim <= 32'h0;
		repeat (2) @(posedge clock);
	endtask
	// expected log occupancy
	task automatic note;
		total++;
		if (fill < 99)
			fill++;
	endtask
	task automatic results;
		if (nFail == 0 && checksDone > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// watchdog
	initial
	begin
		repeat (20000) @(posedge clock);
		nFail++;
		results;
	end
	// main sequence
	initial
	begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		apb(1'b0, `SEL_REG_ENABLE, 32'h0);
		`CHK("enable", 32'h8, rd)
		apb(1'b0, `SEL_REG_UNBAL_LIMIT, 32'h0);
		`CHK("limit", 32'h5, rd)
		apb(1'b0, 12'h040, 32'h0);
		`CHK("slverr", 1'b1, lastErr)
		`CHK("badread", 32'h0, rd)
		foreach (rows[i])
		begin
			apb(1'b1, `SEL_REG_ENABLE, {25'h0, rows[i].en});
			mode <= 4'(i);
			pulse(rows[i].stim);
			if (rows[i].code != 8'h00)
				note();
			apb(1'b0, `SEL_REG_LOG_FILL, 32'h0);
			`CHK("fill", 7'(fill), rd[6:0])
			if (rows[i].code != 8'h00)
			begin
				apb(1'b0, `SEL_REG_LOG_INFO, 32'h0);
				`CHK("code", rows[i].code, rd[11:4])
				`CHK("mode", 4'(i), rd[3:0])
				`CHK("status", {4'h3, rows[i].stim[1:0], rows[i].stim[7:6]}, rd[19:12])
				if (rows[i].code < 8'h36)
					`CHK("bar", rows[i].code, bottomBarCode)
			end
		end
		// alternate loss with interrupt raise and read-clear
		apb(1'b0, `SEL_REG_IRQ_STATUS, 32'h0);
		apb(1'b1, `SEL_REG_IRQ_MASK, 32'h3);
		apb(1'b1, `SEL_REG_ENABLE, 32'h2);
		`CHK("irqidle", 1'b0, irq)
		altPresent <= 1'b0;
		repeat (4) @(posedge clock);
		note();
		`CHK("w30", 1'b1, warnPending[0])
		`CHK("irq", 1'b1, irq)
		apb(1'b0, `SEL_REG_IRQ_STATUS, 32'h0);
		@(negedge clock);
		`CHK("irqclr", 1'b0, irq)
		// generator wait expiry, masked interrupt, clear by source in range
		apb(1'b1, `SEL_REG_IRQ_MASK, 32'h0);
		apb(1'b1, `SEL_REG_ENABLE, 32'h4);
		genStart <= 1'b1;
		repeat (30) @(posedge clock);
		`CHK("w31", 1'b1, warnPending[1])
		`CHK("masked", 1'b0, irq)
		pulse(32'h1);
		note();
		note();
		`CHK("w31clr", 1'b0, warnPending[1])
		apb(1'b1, `SEL_REG_WARN, 32'h3ff);
		@(negedge clock);
		`CHK("ack", 10'h000, warnPending)
		repeat (8) @(posedge clock);
		// overrun the log, then try to clear it
		repeat (100)
		begin
			pulse(32'h400);
			note();
		end
		apb(1'b1, `SEL_REG_LOG_FILL, 32'hffffffff);
		apb(1'b0, `SEL_REG_LOG_FILL, 32'h0);
		`CHK("full", {1'b0, 7'(total % 99), 1'b0, 7'h63}, rd[15:0])
		sel_display_panel_i.look(5'h13, v, c);
		`CHK("v19", 1'b1, v)
		`CHK("c19", 8'h46, c)
		`CHK("s19", 8'h30, dispStatus)
		`CHK("m19", 4'h5, dispMode)
		sel_display_panel_i.look(5'h14, v, c);
		`CHK("v20", 1'b0, v)
		apb(1'b1, `SEL_REG_LOG_INDEX, 32'h62);
		apb(1'b0, `SEL_REG_LOG_INFO, 32'h0);
		`CHK("oldest", 8'h46, rd[11:4])
		results;
	end
endmodule
